/* File: hdl/bsw_regs.svh */
// Purpose: Constants for the battery status word logic.
// Assumes: Command codes are eight bits wide.
// Notes:   Cycle counts derive from the clock rate.
`ifndef BSW_REGS_SVH
`define BSW_REGS_SVH
`define BSW_CMD_CHG_VOLT    8'h15
`define BSW_CMD_STATUS      8'h16
`define BSW_CMD_DEF_LAST    8'h23
`define BSW_CMD_RSVD_LO     8'h1D
`define BSW_CMD_RSVD_HI     8'h1F
`define BSW_CMD_MFR_FIRST   8'h24
`define BSW_BIT_OVC         15
`define BSW_BIT_CHG_STOP    14
`define BSW_BIT_RSVD_HI     13
`define BSW_BIT_OVER_TEMP   12
`define BSW_BIT_DSG_STOP    11
`define BSW_BIT_RSVD_LO     10
`define BSW_BIT_LOW_CAP     9
`define BSW_BIT_LOW_TIME    8
`define BSW_BIT_CFG_VALID   7
`define BSW_BIT_NOT_CHG     6
`define BSW_BIT_FULL        5
`define BSW_BIT_EMPTY       4
`define BSW_ERR_MSB         2
`define BSW_ERR_ALL_ONES    3'h7
`define BSW_EE_FILTER_ADDR  8'h52
`define BSW_EE_FULL_CLR     8'h4B
`define BSW_FILTER_MULT     12'h00A
`define BSW_EMPTY_CLR_PCT   8'h14
`define BSW_VOLT_MAX_MV     16'hF010
`define BSW_VOLT_CUR_SRC    16'hFFFF
`define BSW_WORD_BYTES      6'h02
`define BSW_CLK_HZ          40000000
`define BSW_SEC_TIME_S      1
`define BSW_SEC_CYCLES      (`BSW_CLK_HZ * `BSW_SEC_TIME_S)
`define BSW_STATUS_RST      16'h0040
`endif

/* File: hdl/bsw_pkg.sv */
// Purpose: Types shared by the battery status word logic.
// Assumes: Nothing beyond the constants header.
// Notes:   Structs group the inputs by their source.
package bsw_pkg;
  typedef enum logic [2:0] {
    OK_CODE, BUSY_CODE, RESERVED_CODE, UNIMPLEMENTED_CODE,
    WRITE_REFUSED_CODE, OVERFLOW_CODE, WRONG_BLOCK_SIZE_CODE, UNKNOWN_CODE
  } bsw_err_type;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [5:0] size;
    logic       busy;
    logic       unsupported;
    logic       overflow;
    logic       unknown;
  } bsw_cmd_type;
  typedef struct packed {
    logic [15:0] pack_mv;
    logic [15:0] final_end_threshold;
    logic [15:0] second_end_threshold;
    logic        cell_undervoltage_flag;
    logic [15:0] temperature;
    logic [15:0] max_temperature_limit;
  } bsw_volt_type;
  typedef struct packed {
    logic [15:0] rem_cap_mah;
    logic [15:0] rem_cap_cwh;
    logic [15:0] cap_alarm;
    logic [15:0] tte_cur;
    logic [15:0] tte_pwr;
    logic [15:0] avg_tte_cur;
    logic [15:0] avg_tte_pwr;
    logic [15:0] time_alarm;
  } bsw_cap_type;
  typedef struct packed {
    logic charging;
    logic discharging;
    logic over_limit;
    logic param_bad;
    logic primary_term;
    logic ee_load_ok;
    logic ee_load_bad;
  } bsw_chg_type;
endpackage

/* File: hdl/bsw_status.sv */
// Purpose: Charging voltage request and status word for a smart battery.
// Assumes: A bus engine hands over one command per transaction end.
// Notes:   Reads answer one cycle after the command pulse.
`include "bsw_regs.svh"

module bsw_status #(
  parameter int unsigned SEC_CYCLES = `BSW_SEC_CYCLES
) (
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire bsw_pkg::bsw_cmd_type cmd_i,
  input  wire bsw_pkg::bsw_volt_type volt_i,
  input  wire bsw_pkg::bsw_cap_type cap_i,
  input  wire bsw_pkg::bsw_chg_type chg_i,
  input  wire logic                 capacity_mode_i,
  input  wire logic [15:0]          chg_volt_req_i,
  input  wire logic [7:0]           rel_soc_i,
  input  wire logic [7:0]           full_clr_pct_i,
  input  wire logic [7:0]           filter_byte_i,
  input  wire logic                 alarm_send_i,
  output logic      [15:0]          rd_data_o,
  output logic                      rd_valid_o,
  output logic      [15:0]          alarm_word_o,
  output logic                      alarm_valid_o,
  output logic      [15:0]          status_word_o,
  output logic      [15:0]          chg_volt_o
);
  import bsw_pkg::*;

  // Set wins over clear so a fresh event is never lost.
  function automatic logic upd(input logic cur, input logic set, input logic clr);
    upd = set ? 1'b1 : (clr ? 1'b0 : cur);
  endfunction

  function automatic bsw_err_type classify(input bsw_cmd_type c);
    logic own;
    logic rsvd;
    own  = (c.code == `BSW_CMD_CHG_VOLT) || (c.code == `BSW_CMD_STATUS);
    rsvd = ((c.code >= `BSW_CMD_RSVD_LO) && (c.code <= `BSW_CMD_RSVD_HI))
           || (c.code >= `BSW_CMD_MFR_FIRST);
    if (c.busy)
      classify = BUSY_CODE;
    else if (rsvd && c.unsupported)
      classify = RESERVED_CODE;
    else if (c.unsupported)
      classify = UNIMPLEMENTED_CODE;
    else if (c.write && own)
      classify = WRITE_REFUSED_CODE;
    else if (c.write && (c.size != `BSW_WORD_BYTES))
      classify = WRONG_BLOCK_SIZE_CODE;
    else if (c.overflow)
      classify = OVERFLOW_CODE;
    else if (c.unknown)
      classify = UNKNOWN_CODE;
    else
      classify = OK_CODE;
  endfunction

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

  logic        ovc_ff;
  logic        chg_stop_ff;
  logic        over_temp_ff;
  logic        dsg_stop_ff;
  logic        low_cap_ff;
  logic        low_time_ff;
  logic        cfg_valid_ff;
  logic        not_chg_ff;
  logic        full_ff;
  logic        empty_ff;
  bsw_err_type err_ff;
  logic [31:0] presc_ff;
  logic [11:0] idle_sec_ff;
  logic [15:0] rd_data_ff;
  logic        rd_valid_ff;
  logic [15:0] alarm_word_ff;
  logic        alarm_valid_ff;
  logic [15:0] status_ff;
  logic [15:0] chg_volt_ff;

  // Capacity comparisons pick the unit set by the mode bit.
  wire  [15:0] rem_cap  = capacity_mode_i ? cap_i.rem_cap_cwh : cap_i.rem_cap_mah;
  wire  [15:0] tte      = capacity_mode_i ? cap_i.tte_pwr : cap_i.tte_cur;
  wire  [15:0] avg_tte  = capacity_mode_i ? cap_i.avg_tte_pwr : cap_i.avg_tte_cur;

  wire         active   = chg_i.charging || chg_i.discharging;
  wire  [11:0] idle_lim = 12'(filter_byte_i) * `BSW_FILTER_MULT;
  wire         idle_out = !active && (idle_sec_ff >= idle_lim);
  wire         sec_tick = (presc_ff == SEC_LAST);

  wire         ovc_set  = chg_i.charging && chg_i.over_limit;
  wire         ovc_clr  = chg_i.discharging || idle_out;
  wire         cs_cond  = chg_i.param_bad || chg_i.primary_term;
  wire         cs_clr   = !cs_cond || !chg_i.charging;
  wire         ot_set   = volt_i.temperature > volt_i.max_temperature_limit;
  wire         ds_set   = (volt_i.pack_mv < volt_i.final_end_threshold)
                          || volt_i.cell_undervoltage_flag;
  wire         ds_clr   = (volt_i.pack_mv > volt_i.final_end_threshold)
                          || !volt_i.cell_undervoltage_flag;
  wire         lc_set   = rem_cap < cap_i.cap_alarm;
  wire         lc_clr   = (cap_i.cap_alarm < rem_cap) || chg_i.charging;
  wire         lt_set   = tte < cap_i.time_alarm;
  wire         lt_clr   = (cap_i.time_alarm < avg_tte) || chg_i.charging;
  wire         full_set = chg_i.primary_term || ovc_set;
  wire         full_clr = rel_soc_i <= full_clr_pct_i;
  wire         emp_set  = volt_i.pack_mv < volt_i.second_end_threshold;
  wire         emp_clr  = rel_soc_i >= `BSW_EMPTY_CLR_PCT;

  wire         nxt_ovc       = upd(ovc_ff, ovc_set, ovc_clr);
  wire         nxt_chg_stop  = upd(chg_stop_ff, cs_cond, cs_clr);
  wire         nxt_over_temp = upd(over_temp_ff, ot_set, !ot_set);
  wire         nxt_dsg_stop  = upd(dsg_stop_ff, ds_set, ds_clr);
  wire         nxt_low_cap   = upd(low_cap_ff, lc_set, lc_clr);
  wire         nxt_low_time  = upd(low_time_ff, lt_set, lt_clr);
  wire         nxt_cfg_valid = upd(cfg_valid_ff, chg_i.ee_load_ok, chg_i.ee_load_bad);
  wire         nxt_not_chg   = upd(not_chg_ff, !chg_i.charging, chg_i.charging);
  wire         nxt_full      = upd(full_ff, full_set, full_clr);
  wire         nxt_empty     = upd(empty_ff, emp_set, emp_clr);

  // The word is rebuilt every cycle; reserved masks always read zero.
  logic [15:0] nxt_status;
  always_comb begin
    nxt_status                     = 16'h0000;
    nxt_status[`BSW_BIT_OVC]       = ovc_ff;
    nxt_status[`BSW_BIT_CHG_STOP]  = chg_stop_ff;
    nxt_status[`BSW_BIT_OVER_TEMP] = over_temp_ff;
    nxt_status[`BSW_BIT_DSG_STOP]  = dsg_stop_ff;
    nxt_status[`BSW_BIT_LOW_CAP]   = low_cap_ff;
    nxt_status[`BSW_BIT_LOW_TIME]  = low_time_ff;
    nxt_status[`BSW_BIT_CFG_VALID] = cfg_valid_ff;
    nxt_status[`BSW_BIT_NOT_CHG]   = not_chg_ff;
    nxt_status[`BSW_BIT_FULL]      = full_ff;
    nxt_status[`BSW_BIT_EMPTY]     = empty_ff;
    nxt_status[`BSW_ERR_MSB:0]     = err_ff;
  end

  // Out-of-range requests are clamped, but the special code survives.
  wire         volt_hi      = chg_volt_req_i > `BSW_VOLT_MAX_MV;
  wire         volt_special = chg_volt_req_i == `BSW_VOLT_CUR_SRC;
  wire  [15:0] nxt_chg_volt = (volt_hi && !volt_special) ? `BSW_VOLT_MAX_MV
                                                         : chg_volt_req_i;

  wire         rd_req      = cmd_i.valid && !cmd_i.write && !cmd_i.busy;
  wire         rd_volt     = rd_req && (cmd_i.code == `BSW_CMD_CHG_VOLT);
  wire         rd_stat     = rd_req && (cmd_i.code == `BSW_CMD_STATUS);
  wire  [15:0] nxt_rd_data = rd_volt ? chg_volt_ff : (rd_stat ? status_ff : rd_data_ff);
  wire         nxt_rd_val  = rd_volt || rd_stat;
  wire  [15:0] alarm_image = {status_ff[15:3], `BSW_ERR_ALL_ONES};
  wire  [15:0] nxt_alarm   = alarm_send_i ? alarm_image : alarm_word_ff;
  bsw_err_type nxt_err;
  assign nxt_err = cmd_i.valid ? classify(cmd_i) : err_ff;

  wire  [31:0] nxt_presc    = sec_tick ? 32'h0000_0000 : presc_ff + 32'h0000_0001;
  wire         idle_hold    = idle_sec_ff == 12'hFFF;
  wire  [11:0] nxt_idle_sec = active ? 12'h000
                              : ((sec_tick && !idle_hold) ? idle_sec_ff + 12'h001
                                                          : idle_sec_ff);

  // One short process per flag keeps each reset value next to its update.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ovc_ff <= 1'b0;
    end else if (ce_i) begin
      ovc_ff <= nxt_ovc;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      chg_stop_ff <= 1'b0;
    end else if (ce_i) begin
      chg_stop_ff <= nxt_chg_stop;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      over_temp_ff <= 1'b0;
    end else if (ce_i) begin
      over_temp_ff <= nxt_over_temp;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dsg_stop_ff <= 1'b0;
    end else if (ce_i) begin
      dsg_stop_ff <= nxt_dsg_stop;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      low_cap_ff <= 1'b0;
    end else if (ce_i) begin
      low_cap_ff <= nxt_low_cap;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      low_time_ff <= 1'b0;
    end else if (ce_i) begin
      low_time_ff <= nxt_low_time;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_valid_ff <= 1'b0;
    end else if (ce_i) begin
      cfg_valid_ff <= nxt_cfg_valid;
    end
  end

  // Nothing is charging out of reset, so the not-charging flag starts set.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      not_chg_ff <= 1'b1;
    end else if (ce_i) begin
      not_chg_ff <= nxt_not_chg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      full_ff <= 1'b0;
    end else if (ce_i) begin
      full_ff <= nxt_full;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      empty_ff <= 1'b0;
    end else if (ce_i) begin
      empty_ff <= nxt_empty;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      err_ff <= OK_CODE;
    end else if (ce_i) begin
      err_ff <= nxt_err;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      presc_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      presc_ff <= nxt_presc;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      idle_sec_ff <= 12'h000;
    end else if (ce_i) begin
      idle_sec_ff <= nxt_idle_sec;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd_data_ff     <= 16'h0000;
      rd_valid_ff    <= 1'b0;
      alarm_word_ff  <= 16'h0000;
      alarm_valid_ff <= 1'b0;
      status_ff      <= `BSW_STATUS_RST;
      chg_volt_ff    <= 16'h0000;
    end else if (ce_i) begin
      rd_data_ff     <= nxt_rd_data;
      rd_valid_ff    <= nxt_rd_val;
      alarm_word_ff  <= nxt_alarm;
      alarm_valid_ff <= alarm_send_i;
      status_ff      <= nxt_status;
      chg_volt_ff    <= nxt_chg_volt;
    end
  end

  assign rd_data_o     = rd_data_ff;
  assign rd_valid_o    = rd_valid_ff;
  assign alarm_word_o  = alarm_word_ff;
  assign alarm_valid_o = alarm_valid_ff;
  assign status_word_o = status_ff;
  assign chg_volt_o    = chg_volt_ff;
endmodule // bsw_status

/* File: verification/bsw_status_asserts.sv */
// Purpose: Port-level checks on the status word block.
// Assumes: Flags reach status_word_o two edges after their inputs.
// Notes:   Bound to every bsw_status instance.
module bsw_status_asserts (
  input wire logic                  clock_i,
  input wire logic                  sys_rst_i,
  input wire logic                  ce_i,
  input wire bsw_pkg::bsw_cmd_type  cmd_i,
  input wire bsw_pkg::bsw_volt_type volt_i,
  input wire bsw_pkg::bsw_chg_type  chg_i,
  input wire logic [15:0]           chg_volt_req_i,
  input wire logic                  alarm_send_i,
  input wire logic                  rd_valid_o,
  input wire logic [15:0]           alarm_word_o,
  input wire logic                  alarm_valid_o,
  input wire logic [15:0]           status_word_o,
  input wire logic [15:0]           chg_volt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import bsw_pkg::*;
  logic [15:0] exp_volt;
  logic [12:0] st_hi;
  logic        rd_req;
  logic        cmd_ok;
  assign exp_volt = (chg_volt_req_i > 16'hF010 && chg_volt_req_i != 16'hFFFF) ? 16'hF010
                  : chg_volt_req_i;
  assign st_hi = status_word_o[15:3];
  assign cmd_ok = ce_i && cmd_i.valid && !cmd_i.busy;
  assign rd_req = cmd_ok && !cmd_i.write && (cmd_i.code == 8'h15 || cmd_i.code == 8'h16);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  AST_RD_ANSWER: assert property (rd_req |=> rd_valid_o)
    else $error("read not answered");
  AST_RD_ONLY: assert property (rd_valid_o |-> $past(rd_req))
    else $error("answer without a read");
  AST_VOLT: assert property (ce_i |=> chg_volt_o == $past(exp_volt))
    else $error("voltage request wrong");
  AST_ALARM: assert property (ce_i && alarm_send_i |=>
    alarm_valid_o && alarm_word_o == {$past(st_hi), 3'h7}) else $error("alarm word wrong");
  AST_RSVD: assert property ((status_word_o & 16'h2408) == 16'h0000)
    else $error("reserved bit set");
  AST_NOT_CHG: assert property (ce_i ##1 ce_i |=>
    status_word_o[6] == !$past(chg_i.charging, 2)) else $error("not-charging wrong");
  AST_OVER_TEMP: assert property (ce_i ##1 ce_i |=> status_word_o[12] ==
    ($past(volt_i.temperature, 2) > $past(volt_i.max_temperature_limit, 2)))
    else $error("over-temperature wrong");
  AST_DSG_STOP: assert property (ce_i ##1 ce_i |=> status_word_o[11] ==
    ($past(volt_i.pack_mv, 2) < $past(volt_i.final_end_threshold, 2)
     || $past(volt_i.cell_undervoltage_flag, 2))) else $error("discharge-stop wrong");
  AST_BUSY: assert property (ce_i && cmd_i.valid && cmd_i.busy ##1
    ce_i && !cmd_i.valid |=> status_word_o[2:0] == 3'h1) else $error("busy code missing");
  AST_REFUSED: assert property (cmd_ok && cmd_i.write && !cmd_i.unsupported
    && cmd_i.code == 8'h16 ##1 ce_i && !cmd_i.valid |=> status_word_o[2:0] == 3'h4)
    else $error("refused write code missing");
  COV_READ: cover property (rd_valid_o);
  COV_ALARM: cover property (alarm_valid_o);
  COV_OVC: cover property (status_word_o[15]);
endmodule // bsw_status_asserts

bind bsw_status bsw_status_asserts i_bsw_status_asserts (.clock_i, .sys_rst_i, .ce_i,
  .cmd_i, .volt_i, .chg_i, .chg_volt_req_i, .alarm_send_i, .rd_valid_o, .alarm_word_o,
  .alarm_valid_o, .status_word_o, .chg_volt_o);

/* File: verification/bsw_host_model.sv */
// Purpose: Bus host issuing commands to the block.
// Assumes: The bus engine hands each transaction over as one pulse.
// Notes:   Idle command fields carry the inverse of the last request.
module bsw_host_model import bsw_pkg::*; (
  input  wire logic         clock_i,
  input  wire logic         rd_valid_i,
  input  wire logic [15:0]  rd_data_i,
  output bsw_pkg::bsw_cmd_type cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cmd_o = '0;
  // A refused command gets no answer, so the wait for one is short.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [5:0] s,
                      input logic [3:0] f, output logic [15:0] d, output logic got);
    @(posedge clock_i);
    #2;
    cmd_o = {1'b1, w, c, s, f};
    @(posedge clock_i);
    #2;
    cmd_o = {1'b0, ~w, ~c, ~s, ~f};
    got = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 3 && !got; i++) begin
      if (rd_valid_i === 1'b1) begin
        got = 1'b1;
        d = rd_data_i;
      end else begin
        @(posedge clock_i);
        #2;
      end
    end
  endtask
endmodule // bsw_host_model

/* File: verification/test_battery_status_word_logic.sv */
// Purpose: Self-checking bench for the status word block.
// Assumes: One second is shortened to four clocks.
// Notes:   Inputs change 2 ns after each rising edge.
module test_battery_status_word_logic;
  timeunit 1ns;
  timeprecision 100ps;
  import bsw_pkg::*;
  logic         clock_i, sys_rst_i, ce_i, alarm_send_i, capacity_mode_i, rd_valid_o, alarm_valid_o;
  bsw_cmd_type  cmd;
  bsw_volt_type volt;
  bsw_cap_type  cap;
  bsw_chg_type  chg;
  logic [15:0]  req, rd_data_o, alarm_word_o, status_word_o, chg_volt_o;
  logic [7:0]   soc, clr, filt;
  int           fails, checks;
  bsw_status #(.SEC_CYCLES(4)) i_bsw_status (.clock_i, .sys_rst_i, .ce_i,
    .cmd_i(cmd), .volt_i(volt), .cap_i(cap), .chg_i(chg), .capacity_mode_i,
    .chg_volt_req_i(req), .rel_soc_i(soc), .full_clr_pct_i(clr), .filter_byte_i(filt),
    .alarm_send_i, .rd_data_o, .rd_valid_o, .alarm_word_o, .alarm_valid_o,
    .status_word_o, .chg_volt_o);
  bsw_host_model i_bsw_host_model (.clock_i, .rd_valid_i(rd_valid_o),
    .rd_data_i(rd_data_o), .cmd_o(cmd));
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    logic g;
    i_bsw_host_model.xfer(1'b0, c, 6'h00, 4'h0, d, g);
    if (g !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic expect_word(input logic [15:0] e);
    cyc(3);
    check(status_word_o & 16'hFFF8, e);
  endtask
  task automatic base();
    volt = {16'h3000, 16'h1000, 16'h2000, 1'b0, 16'h0100, 16'h0200};
    cap = {16'h0064, 16'h0064, 16'h0032, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0032};
    chg = '0;
    capacity_mode_i = 1'b0;
    req = 16'h3A98;
    soc = 8'h32;
    clr = 8'h0A;
    filt = 8'h01;
  endtask
  task automatic sc_reset();
    cyc(2);
    check(status_word_o, 16'h0040);
    check(chg_volt_o, 16'h0000);
    sys_rst_i = 1'b0;
  endtask
  task automatic sc_volt();
    logic [15:0] d;
    logic [15:0] inp [5] = '{16'h0000, 16'hF010, 16'hF011, 16'hFFFF, 16'hFFFE};
    logic [15:0] ex [5] = '{16'h0000, 16'hF010, 16'hF010, 16'hFFFF, 16'hF010};
    foreach (inp[i]) begin
      req = inp[i];
      cyc(1);
      rd(8'h15, d);
      check(d, ex[i]);
    end
  endtask
  task automatic sc_flags();
    base();
    volt.temperature = 16'h0300;
    volt.pack_mv = 16'h0100;
    expect_word(16'h1850);
    base();
    expect_word(16'h0040);
    volt.cell_undervoltage_flag = 1'b1;
    expect_word(16'h0840);
    base();
    cap.rem_cap_cwh = 16'h000A;
    cap.tte_pwr = 16'h000A;
    capacity_mode_i = 1'b1;
    expect_word(16'h0340);
    capacity_mode_i = 1'b0;
    expect_word(16'h0040);
    chg.charging = 1'b1;
    chg.over_limit = 1'b1;
    chg.primary_term = 1'b1;
    expect_word(16'hC020);
    chg = '0;
    chg.discharging = 1'b1;
    expect_word(16'h0060);
    soc = 8'h0A;
    expect_word(16'h0040);
    chg.ee_load_ok = 1'b1;
    expect_word(16'h00C0);
    chg.ee_load_ok = 1'b0;
    chg.ee_load_bad = 1'b1;
    expect_word(16'h0040);
  endtask
  task automatic sc_idle();
    base();
    chg.charging = 1'b1;
    chg.over_limit = 1'b1;
    cyc(3);
    chg = '0;
    expect_word(16'h8060);
    cyc(33);
    check(status_word_o & 16'hFFF8, 16'h8060);
    cyc(14);
    check(status_word_o & 16'hFFF8, 16'h0060);
  endtask
  task automatic err(input logic w, input logic [7:0] c, input logic [5:0] s,
                     input logic [3:0] f, input logic [2:0] e);
    logic [15:0] d;
    logic        g;
    i_bsw_host_model.xfer(w, c, s, f, d, g);
    rd(8'h16, d);
    check({13'h0000, d[2:0]}, {13'h0000, e});
  endtask
  task automatic sc_errors();
    logic [15:0] d;
    logic        g;
    base();
    err(1'b0, 8'h16, 6'h00, 4'h8, 3'h1);
    err(1'b0, 8'h1E, 6'h00, 4'h4, 3'h2);
    err(1'b0, 8'h30, 6'h00, 4'h4, 3'h2);
    err(1'b0, 8'h17, 6'h00, 4'h4, 3'h3);
    err(1'b1, 8'h16, 6'h02, 4'h0, 3'h4);
    err(1'b1, 8'h15, 6'h02, 4'h0, 3'h4);
    err(1'b1, 8'h17, 6'h03, 4'h0, 3'h6);
    err(1'b0, 8'h17, 6'h00, 4'h2, 3'h5);
    err(1'b0, 8'h17, 6'h00, 4'h1, 3'h7);
    err(1'b0, 8'h15, 6'h00, 4'h0, 3'h0);
    i_bsw_host_model.xfer(1'b0, 8'h16, 6'h00, 4'h8, d, g);
    cyc(1);
    alarm_send_i = 1'b1;
    cyc(1);
    alarm_send_i = 1'b0;
    check({15'h0000, alarm_valid_o}, 16'h0001);
    check(alarm_word_o, 16'h0067);
  endtask
  // Full is still set from the idle scenario, so it shows while frozen.
  task automatic sc_freeze();
    ce_i = 1'b0;
    volt.temperature = 16'h0300;
    req = 16'h1234;
    cyc(3);
    check(status_word_o & 16'hFFF8, 16'h0060);
    check(chg_volt_o, 16'h3A98);
    sys_rst_i = 1'b1;
    cyc(2);
    check(status_word_o, 16'h0040);
    check(rd_data_o, 16'h0000);
    check(alarm_word_o, 16'h0000);
    check(chg_volt_o, 16'h0000);
    sys_rst_i = 1'b0;
    ce_i = 1'b1;
    expect_word(16'h1040);
    check(chg_volt_o, 16'h1234);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    fails = 0;
    checks = 0;
    sys_rst_i = 1'b1;
    alarm_send_i = 1'b0;
    ce_i = 1'b1;
    base();
    sc_reset();
    sc_volt();
    sc_flags();
    sc_idle();
    sc_errors();
    sc_freeze();
    tally_and_finish();
  end
endmodule // test_battery_status_word_logic
